// ==== verilog/mmiu_unit.sv ====
// Move, extend, external transfer and multiply execution slice
`timescale 1ns/100ps
module mmiu_unit #(
  parameter int NREG = 16
) (
  // Clock, reset, enable
  input wire logic clk,
  input wire logic srst,
  input wire logic clk_en,
  // Mode straps
  input wire logic source_mode,
  input wire logic page_mode,
  // Instruction byte stream from the core
  input wire logic op_valid,
  input wire logic [7:0] op_byte,
  input wire logic [15:0] next_pc,
  input wire logic [1:0] bank_sel,
  // Code memory read answer
  input wire logic code_ready,
  input wire logic [7:0] code_data,
  // External data RAM answer
  input wire logic xram_ready,
  input wire logic [7:0] port0_in,
  input wire logic [7:0] port2_in,
  // Core loads
  input wire logic acc_load,
  input wire logic [7:0] acc_in,
  input wire logic dp_load,
  input wire logic [15:0] dp_in,
  input wire logic p2_load,
  input wire logic [7:0] p2_in,
  input wire logic reg_load,
  input wire logic [5:0] reg_idx,
  input wire logic [7:0] reg_in,
  // Architectural state
  output logic [7:0] accumulator,
  output logic [15:0] data_pointer,
  output logic [15:0] program_counter,
  output logic carry_flag,
  output logic aux_carry_flag,
  output logic overflow_flag,
  output logic negative_flag,
  output logic zero_flag,
  output logic busy,
  output logic illegal_op,
  // Register file read port
  output logic [7:0] reg_rd_data,
  // Code memory request
  output logic code_req,
  output logic [15:0] code_addr,
  // External bus pins
  output logic [7:0] port0_out,
  output logic port0_oe,
  output logic [7:0] port2_out,
  output logic port2_oe,
  output logic xram_rd,
  output logic xram_wr
);
  import mmiu_pkg::*;

  mmiu_state_type state_q; // Decoder state
  logic esc_q; // Escape prefix seen
  logic [7:0] op_q; // Latched opcode
  logic [7:0] fld_q; // Operand field byte
  logic [7:0] imm_hi_q; // Immediate high byte
  logic [7:0] regs_q [2*NREG]; // Byte file; word j sits at bytes 2j and 2j+1
  logic [7:0] acc_q;
  logic [15:0] dp_q;
  logic [15:0] pc_q;
  logic cy_q, ac_q, ov_q, n_q, z_q;
  logic ill_q;
  logic [7:0] rd_q;
  logic creq_q;
  logic [15:0] caddr_q;
  logic [7:0] p0_q, p2_q, p2l_q;
  logic p0oe_q, p2oe_q, xrd_q, xwr_q;
  logic xwrite_q; // Write data has been put on its lane
  logic xlong_q; // External move uses data pointer
  logic [7:0] xaddr_q; // Short address from R0/R1

  // Combinational decode helpers
  logic ext_ok; // Extended opcode allowed now
  logic [15:0] mul_d, mul_s;
  logic [31:0] prod;
  logic m_ov, m_n, m_z;
  logic [4:0] bd, bs; // Byte indices from field
  logic [4:0] bpair; // Even byte of the destination pair
  logic [4:0] wd, ws; // Word base byte indices
  logic [4:0] wpair; // Base byte of destination dword

  // Binary mode demands the escape byte; source mode refuses it
  assign ext_ok = source_mode ? !esc_q : esc_q;

  always_comb begin
    bd = {1'b0, fld_q[7:4]};
    bs = {1'b0, fld_q[3:0]};
    bpair = {1'b0, fld_q[7:5], 1'b0};
    wd = {fld_q[7:4], 1'b0};
    ws = {fld_q[3:0], 1'b0};
    wpair = {fld_q[7:5], 2'b00};
    mul_d = (op_q == OP_MUL_WORD) ? {regs_q[wd], regs_q[wd+5'd1]} : {8'h00, regs_q[bd]};
    mul_s = (op_q == OP_MUL_WORD) ? {regs_q[ws], regs_q[ws+5'd1]} : {8'h00, regs_q[bs]};
  end

  mmiu_multiplier #(.WIDTH(16)) u_mul (
    .word_mode(op_q == OP_MUL_WORD),
    .dest_val(mul_d),
    .src_val(mul_s),
    .product(prod),
    .ovf(m_ov),
    .neg(m_n),
    .zero(m_z)
  );

  // Decoder sequencing; escape is consumed before the opcode
  always_ff @(posedge clk) begin
    if (srst) begin
      state_q <= MMIU_IDLE;
      esc_q <= 1'b0;
      op_q <= RST_BYTE;
      fld_q <= RST_BYTE;
      imm_hi_q <= RST_BYTE;
      ill_q <= 1'b0;
    end else if (clk_en) begin
      ill_q <= 1'b0;
      unique case (state_q)
        MMIU_IDLE: begin
          if (op_valid) begin
            if (op_byte == OP_ESCAPE && !esc_q) begin
              esc_q <= 1'b1;
            end else begin
              op_q <= op_byte;
              esc_q <= 1'b0;
              if (op_byte == OP_CODE_PC || op_byte == OP_CODE_DP ||
                  op_byte == OP_XRD_DP || op_byte == OP_XWR_DP ||
                  op_byte[7:1] == OP_XRD_RI || op_byte[7:1] == OP_XWR_RI) begin
                state_q <= MMIU_XFER;
              end else if (ext_ok && (op_byte == OP_LOAD_HIGH || op_byte == OP_SIGN_EXT ||
                           op_byte == OP_ZERO_EXT || op_byte == OP_MUL_BYTE ||
                           op_byte == OP_MUL_WORD)) begin
                state_q <= MMIU_OPER;
              end else begin
                ill_q <= 1'b1; // Not in this group, or wrong prefix
              end
            end
          end
        end
        MMIU_OPER: begin
          if (op_valid) begin
            fld_q <= op_byte;
            if (op_q == OP_LOAD_HIGH) begin
              if (op_byte[3:0] == LOAD_HIGH_TAIL) begin
                state_q <= MMIU_IMM_HI;
              end else begin
                state_q <= MMIU_IDLE;
                ill_q <= 1'b1;
              end
            end else if (op_q == OP_MUL_BYTE || op_q == OP_MUL_WORD) begin
              // Multiply writes back in the following cycle
              state_q <= MMIU_XFER;
            end else begin
              state_q <= MMIU_IDLE;
            end
          end
        end
        MMIU_IMM_HI: begin
          if (op_valid) begin
            imm_hi_q <= op_byte;
            state_q <= MMIU_IMM_LO;
          end
        end
        MMIU_IMM_LO: begin
          if (op_valid) begin
            state_q <= MMIU_IDLE;
          end
        end
        MMIU_XFER: begin
          if ((creq_q && code_ready) || ((xrd_q || xwr_q) && xram_ready) ||
              op_q == OP_MUL_BYTE || op_q == OP_MUL_WORD) begin
            state_q <= MMIU_IDLE;
          end
        end
        default: state_q <= MMIU_IDLE;
      endcase
    end
  end

  // Register file writes: core loads, extensions, load high, multiply
  always_ff @(posedge clk) begin
    if (srst) begin
      for (int i = 0; i < 2 * NREG; i++) begin
        regs_q[i] <= RST_BYTE;
      end
    end else if (clk_en) begin
      if (reg_load) begin
        regs_q[reg_idx[4:0]] <= reg_in;
      end
      if (state_q == MMIU_OPER && op_valid) begin
        // Word registers are big endian: high byte at even index
        if (op_q == OP_SIGN_EXT) begin
          regs_q[{op_byte[7:4], 1'b0} + 5'd1] <= regs_q[{1'b0, op_byte[3:0]}];
          regs_q[{op_byte[7:4], 1'b0}] <= {8{regs_q[{1'b0, op_byte[3:0]}][7]}};
        end else if (op_q == OP_ZERO_EXT) begin
          regs_q[{op_byte[7:4], 1'b0} + 5'd1] <= regs_q[{1'b0, op_byte[3:0]}];
          regs_q[{op_byte[7:4], 1'b0}] <= RST_BYTE;
        end
      end
      if (state_q == MMIU_IMM_LO && op_valid) begin
        // Only the top word is touched; low word left alone
        regs_q[{fld_q[6:4], 2'b00}] <= imm_hi_q;
        regs_q[{fld_q[6:4], 2'b01}] <= op_byte;
      end
      if (state_q == MMIU_XFER && op_q == OP_MUL_BYTE) begin
        regs_q[bpair] <= prod[15:8];
        regs_q[bpair + 5'd1] <= prod[7:0];
      end else if (state_q == MMIU_XFER && op_q == OP_MUL_WORD) begin
        regs_q[wpair] <= prod[31:24];
        regs_q[wpair + 5'd1] <= prod[23:16];
        regs_q[wpair + 5'd2] <= prod[15:8];
        regs_q[wpair + 5'd3] <= prod[7:0];
      end
    end
  end

  // Multiply completes one cycle after its field byte
  // Flags; only the multiply touches them
  always_ff @(posedge clk) begin
    if (srst) begin
      cy_q <= 1'b0;
      ac_q <= 1'b0;
      ov_q <= 1'b0;
      n_q <= 1'b0;
      z_q <= 1'b0;
    end else if (clk_en) begin
      if (state_q == MMIU_XFER && (op_q == OP_MUL_BYTE || op_q == OP_MUL_WORD)) begin
        cy_q <= 1'b0;
        ov_q <= m_ov;
        n_q <= m_n;
        z_q <= m_z;
      end
      // Moves and transfers never write flags; aux carry kept here as state
      ac_q <= ac_q;
    end
  end

  // Accumulator, pointer, PC and port 2 latch
  always_ff @(posedge clk) begin
    if (srst) begin
      acc_q <= RST_BYTE;
      dp_q <= RST_WORD;
      pc_q <= RST_WORD;
      p2l_q <= RST_BYTE;
    end else if (clk_en) begin
      if (acc_load) acc_q <= acc_in;
      if (dp_load) dp_q <= dp_in; // Never altered by the table read
      if (p2_load) p2l_q <= p2_in;
      if (state_q == MMIU_IDLE && op_valid && op_byte == OP_CODE_PC) begin
        pc_q <= next_pc;
      end
      if (state_q == MMIU_XFER && creq_q && code_ready) begin
        acc_q <= code_data;
      end
      if (state_q == MMIU_XFER && xrd_q && xram_ready) begin
        acc_q <= (page_mode ? port2_in : port0_in);
      end
    end
  end

  // Bus requests: code fetch and external RAM cycle
  always_ff @(posedge clk) begin
    if (srst) begin
      creq_q <= 1'b0;
      caddr_q <= RST_WORD;
      xrd_q <= 1'b0;
      xwr_q <= 1'b0;
      p0_q <= RST_BYTE;
      p2_q <= RST_BYTE;
      p0oe_q <= 1'b0;
      p2oe_q <= 1'b0;
      xlong_q <= 1'b0;
      xwrite_q <= 1'b0;
      xaddr_q <= RST_BYTE;
      rd_q <= RST_BYTE;
    end else if (clk_en) begin
      rd_q <= regs_q[reg_idx[4:0]];
      if (state_q == MMIU_IDLE && op_valid) begin
        if (op_byte == OP_CODE_PC) begin
          creq_q <= 1'b1;
          caddr_q <= next_pc + {8'h00, acc_q};
        end else if (op_byte == OP_CODE_DP) begin
          creq_q <= 1'b1;
          caddr_q <= dp_q + {8'h00, acc_q};
        end else if (op_byte == OP_XRD_DP || op_byte == OP_XWR_DP) begin
          xrd_q <= (op_byte == OP_XRD_DP);
          xwr_q <= (op_byte == OP_XWR_DP);
          xlong_q <= 1'b1;
          p0_q <= dp_q[7:0];
          p2_q <= dp_q[15:8];
          p0oe_q <= 1'b1;
          p2oe_q <= 1'b1;
        end else if (op_byte[7:1] == OP_XRD_RI || op_byte[7:1] == OP_XWR_RI) begin
          xrd_q <= (op_byte[7:1] == OP_XRD_RI);
          xwr_q <= (op_byte[7:1] == OP_XWR_RI);
          xlong_q <= 1'b0;
          // Each bank spans four bytes, so bank 3 stays inside the file
          xaddr_q <= regs_q[{1'b0, bank_sel, 1'b0, op_byte[0]}];
          p0_q <= regs_q[{1'b0, bank_sel, 1'b0, op_byte[0]}];
          p2_q <= p2l_q;
          p0oe_q <= 1'b1;
          p2oe_q <= page_mode;
        end
      end else if (state_q == MMIU_XFER) begin
        if (creq_q && code_ready) begin
          creq_q <= 1'b0;
        end
        if (xwr_q && !xwrite_q) begin
          // Data phase: write data goes where the mode multiplexes it
          xwrite_q <= 1'b1;
          if (page_mode) p2_q <= acc_q;
          else p0_q <= acc_q;
        end else if (xrd_q && !xwrite_q) begin
          // Release the data lane so the RAM can answer
          if (page_mode) p2oe_q <= 1'b0;
          else p0oe_q <= 1'b0;
        end
        if ((xrd_q || xwr_q) && xram_ready) begin
          xrd_q <= 1'b0;
          xwr_q <= 1'b0;
          xwrite_q <= 1'b0;
          p0oe_q <= 1'b0;
          p2oe_q <= 1'b0;
        end
      end
    end
  end

  // Outputs come straight from flip-flops, except busy decoded from state_q
  assign accumulator = acc_q;
  assign data_pointer = dp_q;
  assign program_counter = pc_q;
  assign carry_flag = cy_q;
  assign aux_carry_flag = ac_q;
  assign overflow_flag = ov_q;
  assign negative_flag = n_q;
  assign zero_flag = z_q;
  assign busy = (state_q != MMIU_IDLE);
  assign illegal_op = ill_q;
  assign reg_rd_data = rd_q;
  assign code_req = creq_q;
  assign code_addr = caddr_q;
  assign port0_out = p0_q;
  assign port0_oe = p0oe_q;
  assign port2_out = p2_q;
  assign port2_oe = p2oe_q;
  assign xram_rd = xrd_q;
  assign xram_wr = xwr_q;

  // Multiply clears carry; flag, table address, pointer and long address checks
  a_mul_carry: assert property (@(posedge clk) disable iff (srst)
    (clk_en && state_q == MMIU_XFER && op_q == OP_MUL_BYTE) |=> !cy_q)
    else $error("multiply left carry set");
  a_mul_zero: assert property (@(posedge clk) disable iff (srst)
    (clk_en && state_q == MMIU_XFER && op_q == OP_MUL_WORD) |=> (z_q == $past(prod == 32'h0)))
    else $error("zero flag wrong after multiply");
  a_byte_ovf: assert property (@(posedge clk) disable iff (srst)
    (clk_en && state_q == MMIU_XFER && op_q == OP_MUL_BYTE) |=> (ov_q == ($past(prod) > 32'd255)))
    else $error("byte overflow flag wrong");
  a_word_neg: assert property (@(posedge clk) disable iff (srst)
    (clk_en && state_q == MMIU_XFER && op_q == OP_MUL_WORD) |=> (n_q == $past(prod[31])))
    else $error("negative flag wrong");
  a_pc_table: assert property (@(posedge clk) disable iff (srst)
    (clk_en && state_q == MMIU_IDLE && op_valid && op_byte == OP_CODE_PC)
    |=> (code_req && code_addr == $past(next_pc) + {8'h00, $past(acc_q)}))
    else $error("pc table address wrong");
  a_dp_kept: assert property (@(posedge clk) disable iff (srst)
    (clk_en && !dp_load) |=> $stable(dp_q))
    else $error("data pointer changed");
  a_long_addr: assert property (@(posedge clk) disable iff (srst)
    (clk_en && state_q == MMIU_IDLE && op_valid && op_byte == OP_XRD_DP)
    |=> (port2_out == $past(dp_q[15:8]) && port0_out == $past(dp_q[7:0])))
    else $error("long external address wrong");
  a_move_flags: assert property (@(posedge clk) disable iff (srst)
    (clk_en && op_q != OP_MUL_BYTE && op_q != OP_MUL_WORD) |=> $stable(ov_q))
    else $error("move altered overflow");
endmodule // mmiu_unit

// ==== verilog/mmiu_pkg.sv ====
// Package for the move and multiply instruction unit: opcodes, load high field tail, reset values
package mmiu_pkg;
  // Opcode bytes
  localparam logic [7:0] OP_ESCAPE = 8'hA5;
  localparam logic [7:0] OP_CODE_PC = 8'h83;
  localparam logic [7:0] OP_CODE_DP = 8'h93;
  localparam logic [7:0] OP_LOAD_HIGH = 8'h7A;
  localparam logic [3:0] LOAD_HIGH_TAIL = 4'hC;
  localparam logic [7:0] OP_SIGN_EXT = 8'h1A;
  localparam logic [7:0] OP_ZERO_EXT = 8'h0A;
  localparam logic [7:0] OP_MUL_BYTE = 8'hAC;
  localparam logic [7:0] OP_MUL_WORD = 8'hAD;
  localparam logic [7:0] OP_XRD_DP = 8'hE0;
  localparam logic [6:0] OP_XRD_RI = 7'h71;
  localparam logic [7:0] OP_XWR_DP = 8'hF0;
  localparam logic [6:0] OP_XWR_RI = 7'h79;
  // Reset values
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [15:0] RST_WORD = 16'h0000;
  // Overflow limits
  localparam logic [15:0] BYTE_LIMIT = 16'h00FF;
  localparam logic [31:0] WORD_LIMIT = 32'h0000FFFF;
  // Decoder states
  typedef enum logic [2:0] {
    MMIU_IDLE = 3'b000,
    MMIU_OPER = 3'b001,
    MMIU_IMM_HI = 3'b010,
    MMIU_IMM_LO = 3'b011,
    MMIU_XFER = 3'b100
  } mmiu_state_type;
endpackage

// ==== verilog/mmiu_multiplier.sv ====
// Unsigned multiplier with flag generation for the register multiply
`timescale 1ns/100ps
module mmiu_multiplier #(
  parameter int WIDTH = 16
) (
  // Operands
  input wire logic word_mode,
  input wire logic [WIDTH-1:0] dest_val,
  input wire logic [WIDTH-1:0] src_val,
  // Results
  output logic [2*WIDTH-1:0] product,
  output logic ovf,
  output logic neg,
  output logic zero
);
  import mmiu_pkg::*;
  logic [2*WIDTH-1:0] prod_b; // Byte product, zero extended

  // Both operands unsigned; byte mode uses only low bytes
  always_comb begin
    // Operands widened first so the byte product keeps all 16 bits
    prod_b = {{(2*WIDTH-16){1'b0}}, ({8'h00, dest_val[7:0]} * {8'h00, src_val[7:0]})};
    product = word_mode ? ({{WIDTH{1'b0}}, dest_val} * {{WIDTH{1'b0}}, src_val}) : prod_b;
    // Overflow: above 255 for byte, above FFFF for word
    ovf = word_mode ? (product > WORD_LIMIT) : (product > {16'h0000, BYTE_LIMIT});
    // Negative follows product msb of the operand size
    neg = word_mode ? product[31] : product[15];
    zero = (product == '0);
  end
endmodule // mmiu_multiplier

// ==== tb/mmiu_xram_model.sv ====
// External data RAM model answering on the multiplexed port pins
`timescale 1ns/100ps
module mmiu_xram_model (
  // Clock, lane mode and answer delay
  input wire logic clk,
  input wire logic page_mode,
  input wire logic [2:0] xwait,
  // Pins driven by the unit
  input wire logic [7:0] port0_out,
  input wire logic [7:0] port2_out,
  input wire logic xram_rd,
  input wire logic xram_wr,
  // Answer to the unit
  output logic xram_ready,
  output logic [7:0] port0_in,
  output logic [7:0] port2_in,
  // Last cycle seen, for the bench
  output logic [7:0] last_lo,
  output logic [7:0] last_hi,
  output logic [7:0] last_wr
);
  // Cycles the current request has stood
  int cnt = 0;

  // Start from known pins so the first released value is defined
  initial begin
    xram_ready = 1'b0;
    port0_in = 8'h00;
    port2_in = 8'h00;
    last_lo = 8'h00;
    last_hi = 8'h00;
    last_wr = 8'h00;
  end

  // Pins change just after the edge, like every other driver
  always @(posedge clk) begin
    #10ns;
    if ((xram_rd || xram_wr) && !xram_ready) begin
      // Address lanes are latched on the first cycle of a request
      if (cnt == 0) begin
        last_lo = port0_out;
        last_hi = port2_out;
      end
      cnt = cnt + 1;
    end else begin
      cnt = 0;
    end
    // Slow answers are made by raising xwait
    xram_ready = (cnt > xwait);
    // Write data is taken from the lane of the current mode
    if (xram_ready && xram_wr) begin
      last_wr = page_mode ? port2_out : port0_out;
    end
    // Read data only while ready; a released lane toggles so stale values never match
    port0_in = (xram_ready && xram_rd && !page_mode) ? (last_lo ^ 8'h3C) : ~port0_in;
    port2_in = (xram_ready && xram_rd && page_mode) ? (last_lo ^ 8'h3C) : ~port2_in;
  end
endmodule // mmiu_xram_model

// ==== tb/testbench.sv ====
// Self-checking bench for the move and multiply instruction unit
`timescale 1ns/100ps
`define chk(nm, exp, got) begin checks++; if ((got) !== (exp)) begin err_count++; \
  $display("mismatch %s expected %h seen %h", nm, exp, got); end end
module testbench;
  import mmiu_pkg::*;
  localparam time DLY = 10ns;
  // Bench drives, all defined at time zero
  logic clk = 1'b0, srst = 1'b1, source_mode = 1'b0, page_mode = 1'b0, code_ready = 1'b0;
  logic op_valid = 1'b0, acc_load = 1'b0, dp_load = 1'b0, p2_load = 1'b0, reg_load = 1'b0;
  logic [7:0] op_byte = 8'h00, acc_in = 8'h00, p2_in = 8'h00, reg_in = 8'h00;
  logic [7:0] code_data = 8'h00;
  logic [15:0] next_pc = 16'h0000, dp_in = 16'h0000, last_caddr;
  logic [5:0] reg_idx = 6'h00;
  logic [1:0] bank_sel = 2'b00;
  logic [2:0] xwait = 3'h1;
  // Unit and model outputs
  logic [7:0] accumulator, reg_rd_data, port0_out, port2_out, port0_in, port2_in;
  logic [7:0] last_lo, last_hi, last_wr;
  logic [15:0] data_pointer, program_counter, code_addr;
  logic carry_flag, aux_carry_flag, overflow_flag, negative_flag, zero_flag;
  logic busy, illegal_op, code_req, port0_oe, port2_oe, xram_rd, xram_wr, xram_ready;
  logic [4:0] flags, exp_fl;
  int err_count = 0, checks = 0, ill_cnt = 0, cwait = 0, ill;
  assign flags = {carry_flag, aux_carry_flag, overflow_flag, negative_flag, zero_flag};

  always #50ns clk = ~clk;

  mmiu_unit #(.NREG(16)) uut (.clk(clk), .srst(srst), .clk_en(1'b1),
    .source_mode(source_mode), .page_mode(page_mode), .op_valid(op_valid),
    .op_byte(op_byte), .next_pc(next_pc), .bank_sel(bank_sel), .code_ready(code_ready),
    .code_data(code_data), .xram_ready(xram_ready), .port0_in(port0_in),
    .port2_in(port2_in), .acc_load(acc_load), .acc_in(acc_in), .dp_load(dp_load),
    .dp_in(dp_in), .p2_load(p2_load), .p2_in(p2_in), .reg_load(reg_load),
    .reg_idx(reg_idx), .reg_in(reg_in), .accumulator(accumulator),
    .data_pointer(data_pointer), .program_counter(program_counter),
    .carry_flag(carry_flag), .aux_carry_flag(aux_carry_flag),
    .overflow_flag(overflow_flag), .negative_flag(negative_flag), .zero_flag(zero_flag),
    .busy(busy), .illegal_op(illegal_op), .reg_rd_data(reg_rd_data),
    .code_req(code_req), .code_addr(code_addr), .port0_out(port0_out),
    .port0_oe(port0_oe), .port2_out(port2_out), .port2_oe(port2_oe),
    .xram_rd(xram_rd), .xram_wr(xram_wr));

  mmiu_xram_model xram (.clk(clk), .page_mode(page_mode), .xwait(xwait),
    .port0_out(port0_out), .port2_out(port2_out), .xram_rd(xram_rd), .xram_wr(xram_wr),
    .xram_ready(xram_ready), .port0_in(port0_in), .port2_in(port2_in),
    .last_lo(last_lo), .last_hi(last_hi), .last_wr(last_wr));

  // Code memory content is a fixed mix of the address bytes
  function automatic logic [7:0] cfn(input logic [15:0] a);
    return a[7:0] ^ a[15:8] ^ 8'hC3;
  endfunction

  // Code memory answers two cycles after a request; idle data toggles
  always @(posedge clk) begin
    #DLY;
    cwait = (code_req === 1'b1 && !code_ready) ? cwait + 1 : 0;
    code_ready = (cwait == 2);
    if (code_ready) last_caddr = code_addr;
    code_data = code_ready ? cfn(code_addr) : ~code_data;
  end

  // Count refusal pulses; the edge sees the value before its own update
  always @(posedge clk) if (illegal_op === 1'b1) ill_cnt++;

  task automatic end_of_test();
    if (err_count == 0 && checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  // One instruction byte per cycle; valid stays up between bytes
  task automatic put(input logic [7:0] b);
    op_valid = 1'b1;
    op_byte = b;
    @(posedge clk);
    #DLY;
  endtask

  // Escape byte needed by extended ops in binary mode only
  task automatic pre();
    if (!source_mode) put(OP_ESCAPE);
  endtask

  // Drop valid, wait for idle under a bound, then let results land
  task automatic done();
    int n;
    op_valid = 1'b0;
    for (n = 0; n < 40 && busy !== 1'b0; n++) begin
      @(posedge clk);
      #DLY;
    end
    `chk("busy", 1'b0, busy)
    @(posedge clk);
    #DLY;
  endtask

  // Ends any core load pulse; the idle cycle keeps two loads apart
  task automatic settle();
    @(posedge clk);
    #DLY;
    acc_load = 1'b0;
    dp_load = 1'b0;
    p2_load = 1'b0;
    reg_load = 1'b0;
    @(posedge clk);
    #DLY;
  endtask

  task automatic wr_reg(input int i, input logic [7:0] v);
    reg_load = 1'b1;
    reg_idx = 6'(i);
    reg_in = v;
    settle();
  endtask

  // Read data is registered, so wait for it before comparing
  task automatic ck_reg(input int i, input logic [7:0] v);
    reg_idx = 6'(i);
    repeat (2) @(posedge clk);
    #DLY;
    `chk("byte_register", v, reg_rd_data)
  endtask

  // Loads both operands, multiplies, checks the register pair and flags
  task automatic mul(input bit wd, input int d, input int s, input logic [15:0] dv,
    input logic [15:0] sv);
    logic [31:0] p;
    int h;
    int l;
    p = wd ? dv * sv : dv[7:0] * sv[7:0];
    h = d & ~1;
    l = d | 1;
    wr_reg(wd ? 2 * d : d, wd ? dv[15:8] : dv[7:0]);
    if (wd) wr_reg(2 * d + 1, dv[7:0]);
    wr_reg(wd ? 2 * s : s, wd ? sv[15:8] : sv[7:0]);
    if (wd) wr_reg(2 * s + 1, sv[7:0]);
    pre();
    put(wd ? OP_MUL_WORD : OP_MUL_BYTE);
    put({4'(d), 4'(s)});
    done();
    if (wd) begin
      ck_reg(2 * h, p[31:24]);
      ck_reg(2 * h + 1, p[23:16]);
      ck_reg(2 * l, p[15:8]);
      ck_reg(2 * l + 1, p[7:0]);
    end else begin
      ck_reg(h, p[15:8]);
      ck_reg(l, p[7:0]);
    end
    exp_fl = {2'b00, wd ? p > 32'h0000FFFF : p > 32'h000000FF, wd ? p[31] : p[15], p == 0};
    `chk("flags", exp_fl, flags)
  endtask

  // Table read from code memory, based on the program counter or the pointer
  task automatic tread(input bit usepc, input logic [7:0] a, input logic [15:0] base);
    logic [15:0] ea;
    ea = base + {8'h00, a};
    acc_load = 1'b1;
    acc_in = a;
    dp_load = !usepc;
    dp_in = base;
    settle();
    next_pc = base;
    last_caddr = ~ea;
    put(usepc ? OP_CODE_PC : OP_CODE_DP);
    done();
    `chk("code_addr", ea, last_caddr)
    `chk("accumulator", cfn(ea), accumulator)
    if (usepc) `chk("program_counter", base, program_counter)
    else `chk("data_pointer", base, data_pointer)
    `chk("flags", exp_fl, flags)
  endtask

  // External move; reads expect the model's data, writes the accumulator value
  task automatic xm(input logic [7:0] op, input logic [7:0] lo, input logic [7:0] av);
    put(op);
    `chk("port_oe", {1'b1, !op[1] || page_mode}, {port0_oe, port2_oe})
    done();
    `chk("xram_addr_low", lo, last_lo)
    if (op[1] && page_mode) `chk("xram_addr_high", 8'h7C, last_hi)
    if (op[4]) `chk("xram_data", av, last_wr)
    else `chk("accumulator", lo ^ 8'h3C, accumulator)
    `chk("flags", exp_fl, flags)
  endtask

  // Main sequence
  initial begin
    logic [31:0] dw;
    logic [7:0] v;
    repeat (12) @(posedge clk);
    #DLY;
    srst = 1'b0;
    @(posedge clk);
    #DLY;
    `chk("reset_state", '0, {accumulator, data_pointer, program_counter, flags, busy, xram_rd})
    // Multiplies in binary mode, boundaries of both overflow limits
    mul(0, 1, 0, 16'h0050, 16'h00A0);
    mul(0, 2, 3, 16'h0000, 16'h0077);
    mul(0, 6, 7, 16'h000F, 16'h0011);
    mul(1, 0, 2, 16'h1234, 16'h0100);
    mul(1, 3, 4, 16'hFFFF, 16'hFFFF);
    mul(1, 4, 6, 16'h00FF, 16'h0101);
    mul(0, 4, 9, 16'h00FF, 16'h00FF);
    // Load high word with escape; low word must survive
    dw = 32'h55667788;
    for (int i = 0; i < 4; i++) wr_reg(i, dw[31 - 8 * i -: 8]);
    pre();
    put(OP_LOAD_HIGH);
    put({4'h0, LOAD_HIGH_TAIL});
    put(8'h11);
    put(8'h22);
    done();
    dw = 32'h11227788;
    for (int i = 0; i < 4; i++) ck_reg(i, dw[31 - 8 * i -: 8]);
    `chk("flags", exp_fl, flags)
    // Extended ops without escape in binary mode are refused
    for (int i = 0; i < 4; i++) begin
      ill = ill_cnt;
      put(i[1] ? (i[0] ? OP_ZERO_EXT : OP_LOAD_HIGH) : (i[0] ? OP_MUL_BYTE : OP_SIGN_EXT));
      done();
      `chk("illegal_op", ill + 1, ill_cnt)
    end
    // Escape in source mode is refused too
    source_mode = 1'b1;
    ill = ill_cnt;
    put(OP_ESCAPE);
    put(OP_MUL_WORD);
    done();
    `chk("illegal_op", ill + 1, ill_cnt)
    `chk("flags", exp_fl, flags)
    // Extensions without prefix; the zero case must clear a filled upper byte
    for (int k = 0; k < 3; k++) begin
      v = (k == 0) ? 8'h55 : 8'h95;
      wr_reg(5, v);
      put((k == 2) ? OP_ZERO_EXT : OP_SIGN_EXT);
      put(8'h35);
      done();
      ck_reg(6, (k == 2) ? 8'h00 : {8{v[7]}});
      ck_reg(7, v);
      `chk("flags", exp_fl, flags)
    end
    // Table reads, including a carry into the high byte and a wrap
    tread(1, 8'hF0, 16'h12FF);
    tread(1, 8'h20, 16'hFFF0);
    tread(0, 8'h50, 16'h40C0);
    // External moves in both lane modes, prompt and slow answers
    bank_sel = 2'b10;
    wr_reg(8, 8'h12);
    wr_reg(9, 8'h34);
    p2_load = 1'b1;
    p2_in = 8'h7C;
    settle();
    for (int pm = 0; pm < 2; pm++) begin
      page_mode = pm[0];
      xwait = pm[0] ? 3'h4 : 3'h1;
      acc_load = 1'b1;
      acc_in = 8'hA7;
      dp_load = 1'b1;
      dp_in = 16'h3456;
      settle();
      xm(OP_XWR_DP, 8'h56, 8'hA7);
      `chk("xram_addr_high", 8'h34, last_hi)
      xm(OP_XRD_DP, 8'h56, 8'h00);
      xm({OP_XWR_RI, 1'b0}, 8'h12, 8'h6A);
      xm({OP_XRD_RI, 1'b1}, 8'h34, 8'h00);
    end
    end_of_test();
  end

  // Watchdog well beyond the expected run length
  initial begin
    #(20000 * 100ns);
    err_count++;
    end_of_test();
  end
endmodule // testbench
